// file: hdl/adc_ctrl_pkg.sv
// constants, register map and carrier types for the converter control block
package adc_ctrl_pkg;
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFS_RESULT_LOW = 12'h000;
    localparam logic [11:0] OFS_RESULT_HIGH = 12'h004;
    localparam logic [11:0] OFS_CTRL_A = 12'h008;
    localparam logic [11:0] OFS_CTRL_B = 12'h00c;
    localparam logic [11:0] OFS_INPUT_SEL = 12'h010;
    localparam logic [11:0] OFS_POWER = 12'h014;
    localparam logic [11:0] OFS_TRIG_FLAGS = 12'h018;
    // control a fields
    localparam int CA_ENABLE = 7;
    localparam int CA_START = 6;
    localparam int CA_AUTO = 5;
    localparam int CA_DONE = 4;
    localparam int CA_IRQEN = 3;
    localparam int CA_DIV_LSB = 0;
    // input select fields
    localparam int IS_REF_LSB = 6;
    localparam int IS_LEFT = 5;
    localparam int IS_CH_LSB = 0;
    localparam int CH_W = 4;
    localparam int TS_W = 3;
    localparam int DIV_W = 3;
    localparam int RES_W = 10;
    localparam int NTRIG = 8;
    // trigger source 0 is the done flag itself
    localparam logic [2:0] TS_DONE_FLAG = 3'h0;
    localparam logic [7:0] POWER_RESET = 8'h01;
    // timing in converter clock cycles, sample points in converter clock half cycles, trigger sync in cpu clocks
    localparam int NORMAL_CYCLES = 13;
    localparam int FIRST_CYCLES = 25;
    localparam int NORMAL_SAMPLE_HALF = 3;
    localparam int FIRST_SAMPLE_HALF = 27;
    localparam int AUTO_SAMPLE_HALF = 4;
    localparam int SYNC_CPU_CYCLES = 3;
    localparam real CLK_MHZ = 50.0;

    typedef struct packed {
        logic [1:0] refSel;
        logic [CH_W-1:0] channel;
    } analog_sel_t;

    typedef struct packed {
        logic convActive;
        logic sampleHold;
        logic convDone;
    } analog_ctrl_t;
endpackage

// file: hdl/adc_ctrl.sv
// successive approximation converter digital control with APB registers
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module adc_ctrl #(
    parameter int NTRIG = 8
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [adc_ctrl_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NTRIG-1:0] triggerSources,
    input wire logic [adc_ctrl_pkg::RES_W-1:0] coreResult,
    output adc_ctrl_pkg::analog_sel_t analogSel,
    output adc_ctrl_pkg::analog_ctrl_t analogCtrl,
    output logic convIrq
);
    import adc_ctrl_pkg::*;

    typedef enum logic [1:0] {IDLE, WAIT_EDGE, CONVERT} conv_state_t;

    logic [7:0] ctrlA_reg;
    logic [TS_W-1:0] trigSel_reg;
    logic [7:0] inputSel_reg;
    logic powerRed_reg;
    logic [NTRIG-1:0] trigFlag_reg;
    logic [7:0] resLow_reg, resHigh_reg;
    logic readLock_reg;
    analog_sel_t selBuf_reg;
    logic [7:0] presc_reg;
    logic [4:0] cycCnt_reg;
    logic firstConv_reg, autoConv_reg;
    conv_state_t state_reg;
    logic [SYNC_CPU_CYCLES-1:0] trigPipe_reg;
    logic [NTRIG-1:0] trigS1_reg, trigS2_reg, trigPrev_reg;

    wire enable = ctrlA_reg[CA_ENABLE];
    wire autoEn = ctrlA_reg[CA_AUTO];
    wire [DIV_W-1:0] divSel = ctrlA_reg[CA_DIV_LSB +: DIV_W];
    wire wrAcc = psel & penable & pwrite;
    wire rdAcc = psel & penable & ~pwrite;
    wire hitLow = paddr == OFS_RESULT_LOW;
    wire hitHigh = paddr == OFS_RESULT_HIGH;
    wire hitCtrlA = paddr == OFS_CTRL_A;
    wire hitCtrlB = paddr == OFS_CTRL_B;
    wire hitSel = paddr == OFS_INPUT_SEL;
    wire hitPower = paddr == OFS_POWER;
    wire hitFlags = paddr == OFS_TRIG_FLAGS;
    wire mapped = hitLow | hitHigh | hitCtrlA | hitCtrlB | hitSel | hitPower
        | hitFlags;

    // converter clock: power-of-two divider, two cpu clocks minimum
    function automatic logic [7:0] divMask(input logic [DIV_W-1:0] s);
        divMask = (s == 3'h0) ? 8'h01 : 8'(9'h1ff >> (4'd9 - {1'b0, s}));
    endfunction
    wire [7:0] mask = divMask(divSel);
    wire [7:0] half = (mask >> 1) + 8'h01;
    wire halfTick = ((presc_reg & mask) == mask) ||
        ((presc_reg & mask) == (half - 8'h01));
    wire riseTick = (presc_reg & mask) == mask;

    // trigger edge detection and flags set by the sources themselves
    wire [NTRIG-1:0] trigRise = trigS2_reg & ~trigPrev_reg;
    wire selTrig = (trigSel_reg == TS_DONE_FLAG) ? ctrlA_reg[CA_DONE]
        : trigFlag_reg[trigSel_reg];
    logic selTrigPrev_reg;
    wire trigEdge = selTrig & ~selTrigPrev_reg;

    // enable and start may arrive in one write, so the old enable is not used
    wire swStart = wrAcc & hitCtrlA & pwdata[CA_START] & ~powerRed_reg
        & pwdata[CA_ENABLE];
    wire busy = state_reg != IDLE;
    wire autoFire = trigPipe_reg[SYNC_CPU_CYCLES-1];
    wire [4:0] totalCyc = firstConv_reg ? 5'(FIRST_CYCLES)
        : 5'(NORMAL_CYCLES);
    // half-cycle counter for the sample point
    logic [5:0] halfCnt_reg;
    wire [5:0] samplePt = autoConv_reg ? 6'(AUTO_SAMPLE_HALF)
        : firstConv_reg ? 6'(FIRST_SAMPLE_HALF)
        : 6'(NORMAL_SAMPLE_HALF);
    wire lastCycle = (state_reg == CONVERT) && (cycCnt_reg == totalCyc - 5'd1);
    wire complete = lastCycle && riseTick;
    wire doneFree = autoEn && trigSel_reg == TS_DONE_FLAG;

    // result placement
    wire [15:0] placed = inputSel_reg[IS_LEFT] ? {coreResult, 6'h00}
        : {6'h00, coreResult};

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            trigS1_reg <= '0;
            trigS2_reg <= '0;
            trigPrev_reg <= '0;
        end else begin
            trigS1_reg <= triggerSources;
            trigS2_reg <= trigS1_reg;
            trigPrev_reg <= trigS2_reg;
        end
    end

    // prescaler held in reset while disabled, restarted by auto trigger
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            presc_reg <= '0;
        end else if (!enable || (autoFire && !busy && autoEn)) begin
            presc_reg <= '0;
        end else begin
            presc_reg <= presc_reg + 8'h01;
        end
    end

    // trigger synchroniser pipe adds fixed cpu clocks to trigger timing
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            trigPipe_reg <= '0;
            selTrigPrev_reg <= 1'b0;
        end else begin
            selTrigPrev_reg <= selTrig;
            // edges seen while busy are dropped, level at completion ignored
            trigPipe_reg <= {trigPipe_reg[SYNC_CPU_CYCLES-2:0],
                trigEdge & autoEn & enable & ~busy & ~doneFree};
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= IDLE;
            cycCnt_reg <= '0;
            halfCnt_reg <= '0;
            firstConv_reg <= 1'b1;
            autoConv_reg <= 1'b0;
        end else if (!enable) begin
            state_reg <= IDLE;
            cycCnt_reg <= '0;
            halfCnt_reg <= '0;
            firstConv_reg <= 1'b1;
            autoConv_reg <= 1'b0;
        end else begin
            case (state_reg)
                IDLE: begin
                    cycCnt_reg <= '0;
                    halfCnt_reg <= '0;
                    if (autoFire) begin
                        state_reg <= CONVERT;
                        autoConv_reg <= 1'b1;
                    end else if (swStart || ctrlA_reg[CA_START]) begin
                        // a start written with enable is picked up here
                        state_reg <= WAIT_EDGE;
                        autoConv_reg <= 1'b0;
                    end
                end
                WAIT_EDGE: begin
                    if (riseTick) begin
                        state_reg <= CONVERT;
                    end
                end
                CONVERT: begin
                    if (halfTick && halfCnt_reg != 6'h3f) begin
                        halfCnt_reg <= halfCnt_reg + 6'h01;
                    end
                    if (riseTick) begin
                        cycCnt_reg <= cycCnt_reg + 5'd1;
                    end
                    if (complete) begin
                        firstConv_reg <= 1'b0;
                        cycCnt_reg <= '0;
                        halfCnt_reg <= '0;
                        autoConv_reg <= 1'b0;
                        state_reg <= doneFree ? CONVERT : IDLE;
                    end
                end
                default: state_reg <= IDLE;
            endcase
        end
    end

    // selection buffer tracks register while enabled, except in a conversion before its last cycle
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            selBuf_reg <= '0;
        end else if (enable && (state_reg != CONVERT || lastCycle)) begin
            selBuf_reg.refSel <= inputSel_reg[IS_REF_LSB +: 2];
            selBuf_reg.channel <= inputSel_reg[IS_CH_LSB +: CH_W];
        end
    end

    // control a: enable gated by power reduction, start and done by hardware
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ctrlA_reg <= '0;
        end else begin
            if (wrAcc && hitCtrlA) begin
                ctrlA_reg[CA_ENABLE] <= pwdata[CA_ENABLE] & ~powerRed_reg;
                ctrlA_reg[CA_AUTO] <= pwdata[CA_AUTO];
                ctrlA_reg[CA_IRQEN] <= pwdata[CA_IRQEN];
                ctrlA_reg[CA_DIV_LSB +: DIV_W] <= pwdata[CA_DIV_LSB +: DIV_W];
            end
            // start bit: held during conversion, cleared at single completion
            if (swStart || autoFire) begin
                ctrlA_reg[CA_START] <= 1'b1;
            end else if (complete && !doneFree) begin
                ctrlA_reg[CA_START] <= 1'b0;
            end else if (!enable) begin
                ctrlA_reg[CA_START] <= 1'b0;
            end
            if (complete) begin
                ctrlA_reg[CA_DONE] <= 1'b1;
            end else if (wrAcc && hitCtrlA && pwdata[CA_DONE]) begin
                ctrlA_reg[CA_DONE] <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            trigSel_reg <= '0;
        end else if (wrAcc && hitCtrlB) begin
            trigSel_reg <= pwdata[TS_W-1:0];
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            inputSel_reg <= '0;
        end else if (wrAcc && hitSel) begin
            inputSel_reg <= pwdata[7:0];
        end
    end

    // power reduction comes up set, so the converter starts off unusable
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            powerRed_reg <= POWER_RESET[0];
        end else if (wrAcc && hitPower) begin
            powerRed_reg <= pwdata[0];
        end
    end

    // set wins over write-one-to-clear, so no source event is lost
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            trigFlag_reg <= '0;
        end else begin
            trigFlag_reg <= (trigFlag_reg
                & ~((wrAcc && hitFlags) ? pwdata[NTRIG-1:0] : '0))
                | trigRise;
        end
    end

    // result bytes only move while no half-read pair is pending
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            resLow_reg <= '0;
            resHigh_reg <= '0;
        end else if (complete && !readLock_reg) begin
            resLow_reg <= placed[7:0];
            resHigh_reg <= placed[15:8];
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            readLock_reg <= 1'b0;
        end else if (rdAcc && hitLow) begin
            readLock_reg <= 1'b1;
        end else if (rdAcc && hitHigh) begin
            readLock_reg <= 1'b0;
        end
    end

    wire [7:0] ctrlARead = {ctrlA_reg[7], ctrlA_reg[CA_START] | busy,
        ctrlA_reg[5:0]};
    wire [31:0] rdMux = hitLow ? {24'h0, resLow_reg}
        : hitHigh ? {24'h0, resHigh_reg}
        : hitCtrlA ? {24'h0, ctrlARead}
        : hitCtrlB ? {29'h0, trigSel_reg}
        : hitSel ? {24'h0, inputSel_reg}
        : hitPower ? {31'h0, powerRed_reg}
        : hitFlags ? {{(32-NTRIG){1'b0}}, trigFlag_reg}
        : 32'h0;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rdMux;
        end
    end

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign analogSel = selBuf_reg;
    assign analogCtrl.convActive = state_reg == CONVERT;
    assign analogCtrl.sampleHold = state_reg == CONVERT
        && halfCnt_reg == samplePt;
    assign analogCtrl.convDone = complete;
    assign convIrq = ctrlA_reg[CA_DONE] & ctrlA_reg[CA_IRQEN];
endmodule

// file: verif/adc_ctrl_checker.sv
// port-level checks for the converter control block
`timescale 1ns/1ps
module adc_ctrl_checker #(
    parameter int NTRIG = 8
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [adc_ctrl_pkg::ADDR_W-1:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [NTRIG-1:0] triggerSources,
    input wire adc_ctrl_pkg::analog_sel_t analogSel,
    input wire adc_ctrl_pkg::analog_ctrl_t analogCtrl,
    input wire logic convIrq
);
    import adc_ctrl_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    sequence conv_start;
        $rose(analogCtrl.convActive);
    endsequence
    sequence apb_access;
        psel && penable;
    endsequence
    chk_zero_wait: assert property (apb_access |-> pready)
        else $error("access phase without ready");
    chk_bad_addr: assert property (apb_access
        and paddr > OFS_TRIG_FLAGS |-> pslverr)
        else $error("unmapped access without error");
    chk_good_addr: assert property (apb_access
        and paddr <= OFS_TRIG_FLAGS && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("mapped access flagged as error");
    chk_done_pulse: assert property (
        analogCtrl.convDone |=> !analogCtrl.convDone)
        else $error("completion pulse longer than one cycle");
    chk_done_in_conv: assert property (
        analogCtrl.convDone |-> $past(analogCtrl.convActive))
        else $error("completion without a running conversion");
    chk_sel_frozen: assert property (
        conv_start |=> $stable(analogSel)[*4])
        else $error("selection moved early in conversion");
    chk_min_length: assert property (
        conv_start |-> !analogCtrl.convDone[*8])
        else $error("conversion ended too soon");
    chk_sample_in_conv: assert property (
        $rose(analogCtrl.sampleHold) |-> analogCtrl.convActive)
        else $error("sample taken outside conversion");
    chk_irq_cause: assert property (
        $rose(convIrq) |-> $past(analogCtrl.convDone
        || (psel && penable && pwrite)))
        else $error("interrupt rose without cause");
endmodule

bind adc_ctrl adc_ctrl_checker #(.NTRIG(NTRIG)) i_chk (
    .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .triggerSources(triggerSources), .analogSel(analogSel),
    .analogCtrl(analogCtrl), .convIrq(convIrq)
);

// file: verif/adc_core_model.sv
// behavioural analog core: result follows the sampled channel
`timescale 1ns/1ps
module adc_core_model (
    input wire logic core_clk,
    input wire adc_ctrl_pkg::analog_sel_t analogSel,
    input wire adc_ctrl_pkg::analog_ctrl_t analogCtrl,
    output logic [9:0] coreResult
);
    import adc_ctrl_pkg::*;
    logic [9:0] held = 10'h155;
    logic holdPrev = 1'b0;
    always @(posedge core_clk) begin
        holdPrev <= analogCtrl.sampleHold;
        if (analogCtrl.sampleHold && !holdPrev)
            held <= {analogSel.channel, 6'h2a};
    end
    // outside a conversion the value is junk, not the last one
    assign coreResult = (analogCtrl != '0) ? held : ~held;
endmodule

// file: verif/adc_ctrl_tb.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
module adc_ctrl_tb;
    import adc_ctrl_pkg::*;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] triggerSources = 8'h00;
    logic [9:0] coreResult;
    analog_sel_t analogSel;
    analog_ctrl_t analogCtrl;
    logic convIrq;
    logic [31:0] rd;
    logic err;
    int fail_count = 0;
    int samples_checked = 0;
    int n;
    always #10 core_clk = ~core_clk;
    adc_ctrl #(.NTRIG(8)) i_dut (
        .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .triggerSources(triggerSources),
        .coreResult(coreResult), .analogSel(analogSel),
        .analogCtrl(analogCtrl), .convIrq(convIrq)
    );
    adc_core_model i_core (.core_clk(core_clk), .analogSel(analogSel),
        .analogCtrl(analogCtrl), .coreResult(coreResult));
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic hang();
        fail_count++;
        print_verdict();
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 50)
            hang();
    endtask
    task automatic wait_done(output int c);
        c = 0;
        do begin
            @(posedge core_clk);
            c++;
        end while (analogCtrl.convDone !== 1'b1 && c < 400);
        if (c >= 400)
            hang();
    endtask
    task automatic quiet(input int c);
        logic seen;
        seen = 1'b0;
        repeat (c) begin
            @(posedge core_clk);
            seen = seen | analogCtrl.convActive;
        end
        check(32'(seen), 0);
    endtask
    task automatic res(input logic [7:0] lo, input logic [7:0] hi);
        apb(0, OFS_RESULT_LOW, 0);
        check(rd, 32'(lo));
        apb(0, OFS_RESULT_HIGH, 0);
        check(rd, 32'(hi));
    endtask
    task automatic t_first();
        apb(0, OFS_POWER, 0);
        check(rd, 32'(POWER_RESET));
        apb(1, OFS_CTRL_A, 32'hc0);
        quiet(60);
        apb(1, OFS_POWER, 0);
        apb(1, OFS_INPUT_SEL, 32'h03);
        apb(1, OFS_CTRL_A, 32'hc0);
        apb(0, OFS_CTRL_A, 0);
        check(32'(rd[CA_START]), 1);
        wait_done(n);
        check(32'(n + 3 >= 2*FIRST_CYCLES && n <= 2*FIRST_CYCLES), 1);
        apb(0, OFS_CTRL_A, 0);
        check(32'(rd[CA_START]), 0);
        check(32'(rd[CA_DONE]), 1);
        res(8'hea, 8'h00);
        $display("first conversion test done");
    endtask
    task automatic t_left();
        apb(1, OFS_INPUT_SEL, 32'h23);
        apb(1, OFS_CTRL_A, 32'hc0);
        apb(1, OFS_INPUT_SEL, 32'h25);
        wait_done(n);
        check(32'(n + 3 >= 2*NORMAL_CYCLES && n <= 2*NORMAL_CYCLES), 1);
        res(8'h80, 8'h3a);
        apb(1, OFS_CTRL_A, 32'hc0);
        wait_done(n);
        check(32'(n >= 2*NORMAL_CYCLES && n <= 2*NORMAL_CYCLES + 3), 1);
        res(8'h80, 8'h5a);
        $display("left adjust test done");
    endtask
    task automatic t_lock();
        apb(1, OFS_INPUT_SEL, 32'h05);
        apb(1, OFS_CTRL_A, 32'hd8);
        wait_done(n);
        apb(0, OFS_RESULT_LOW, 0);
        check(rd, 32'h6a);
        apb(1, OFS_INPUT_SEL, 32'h06);
        apb(1, OFS_CTRL_A, 32'hd8);
        wait_done(n);
        repeat (2) @(posedge core_clk);
        check(32'(convIrq), 1);
        res(8'h6a, 8'h01);
        apb(1, OFS_CTRL_A, 32'h98);
        repeat (2) @(posedge core_clk);
        check(32'(convIrq), 0);
        $display("read lock test done");
    endtask
    task automatic t_auto();
        apb(1, OFS_CTRL_B, 1);
        apb(1, OFS_CTRL_A, 32'ha0);
        triggerSources <= 8'h02;
        wait_done(n);
        check(32'(n >= 2*NORMAL_CYCLES && n <= 2*NORMAL_CYCLES + 8), 1);
        quiet(80);
        apb(0, OFS_TRIG_FLAGS, 0);
        check(32'(rd[1]), 1);
        triggerSources <= 8'h00;
        apb(1, OFS_TRIG_FLAGS, 32'h2);
        triggerSources <= 8'h02;
        wait_done(n);
        apb(1, OFS_CTRL_A, 32'he0);
        wait_done(n);
        quiet(60);
        $display("auto trigger test done");
    endtask
    task automatic t_free();
        apb(1, OFS_CTRL_B, 32'(TS_DONE_FLAG));
        apb(1, OFS_CTRL_A, 32'he0);
        wait_done(n);
        wait_done(n);
        apb(0, OFS_CTRL_A, 0);
        check(32'(rd[CA_START]), 1);
        apb(1, OFS_CTRL_A, 0);
        // state leaves the conversion one clock after the disabling write
        @(posedge core_clk);
        quiet(60);
        apb(0, 12'h01c, 0);
        check({rd[30:0], err}, 32'h1);
        $display("free running test done");
    endtask
    initial begin
        repeat (10) @(posedge core_clk);
        rstn <= 1'b1;
        t_first();
        t_left();
        t_lock();
        t_auto();
        t_free();
        print_verdict();
    end
endmodule
